/* rtl/pt_timer.v */
`include "pt_timer_consts.vh"

module pt_timer (
	input  wire        core_clk,
	input  wire        srst,
	input  wire [4:0]  avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [31:0] avs_writedata,
	output reg  [31:0] avs_readdata,
	output wire        avs_waitrequest,
	input  wire        external_reset_input,
	output reg         pwm_out,
	output reg  [7:0]  tb_count,
	output reg         period_match
);

	// Mode decoding
	function is_oneshot;
		input [4:0] m;
		begin
			is_oneshot = (m >= `PT_MODE_OS_SW) && (m <= `PT_MODE_LR_HI);
		end
	endfunction

	function is_edge_start;
		input [4:0] m;
		begin
			is_edge_start = (m >= `PT_MODE_OS_RISE) && (m <= `PT_MODE_LR_HI);
		end
	endfunction

	function is_lvl_limit;
		input [4:0] m;
		begin
			is_lvl_limit = (m == `PT_MODE_LVL_LO) || (m == `PT_MODE_LVL_HI);
		end
	endfunction

	function is_lvl_oneshot;
		input [4:0] m;
		begin
			is_lvl_oneshot = (m == `PT_MODE_LR_LO) || (m == `PT_MODE_LR_HI);
		end
	endfunction

	function is_hl_oneshot;
		input [4:0] m;
		begin
			is_hl_oneshot = (m == `PT_MODE_HL_RISE) || (m == `PT_MODE_HL_FALL);
		end
	endfunction

	function is_edge_limit;
		input [4:0] m;
		begin
			is_edge_limit = (m >= `PT_MODE_LIM_ANY) && (m <= `PT_MODE_LIM_FALL);
		end
	endfunction

	reg        ack_reg;
	reg [7:0]  period_reg;
	reg [7:0]  duty_reg;
	reg [4:0]  mode_reg;
	reg [7:0]  clkdiv_reg;
	reg        run_reg;
	reg [7:0]  div_cnt_reg;
	reg        tick_reg;
	reg        run_s1_reg;
	reg        run_s2_reg;
	reg        run_prev_reg;
	reg        ers_s1_reg;
	reg        ers_s2_reg;
	reg        ers_prev_reg;
	reg        started_reg;
	reg [1:0]  hold_reg;
	reg [1:0]  lvl_cnt_reg;

	wire       bus_req;
	wire       do_write;
	wire       wr_count;
	wire       wr_ctrl;
	wire       run;
	wire       rise;
	wire       fall;
	wire       sel_edge;
	wire       gate_ok;
	wire       lvl_rst;
	wire       lvl_held;
	wire       lvl_release;
	wire       start_evt;
	wire       retrig_evt;
	wire       match;
	wire       duty_hit;
	wire       sw_start;
	wire       hw_clr_run;
	reg        inc_raw;
	wire       inc;
	wire       pwm_set;
	wire       pwm_clr;
	reg [31:0] rd_next;

	// Avalon slave: one wait cycle on every access
	assign bus_req         = avs_read | avs_write;
	assign avs_waitrequest = bus_req & ~ack_reg;
	assign do_write        = avs_write & ack_reg;
	assign wr_count        = do_write && (avs_address == `PT_OFS_COUNT);
	assign wr_ctrl         = do_write && (avs_address == `PT_OFS_CTRL);

	always @(posedge core_clk) begin
		if (srst) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= bus_req & ~ack_reg;
		end
	end

	always @* begin
		rd_next = 32'h0000_0000;
		case (avs_address)
			`PT_OFS_COUNT: begin
				rd_next[7:0] = tb_count;
			end
			`PT_OFS_PERIOD: begin
				rd_next[7:0] = period_reg;
			end
			`PT_OFS_CTRL: begin
				rd_next[`PT_CTRL_RUN_BIT] = run_reg;
				rd_next[`PT_CTRL_MODE_MSB:`PT_CTRL_MODE_LSB] = mode_reg;
			end
			`PT_OFS_DUTY: begin
				rd_next[7:0] = duty_reg;
			end
			`PT_OFS_STATUS: begin
				rd_next[`PT_STAT_PWM_BIT] = pwm_out;
				rd_next[`PT_STAT_RUN_BIT] = run_s2_reg;
				rd_next[`PT_STAT_ARM_BIT] = started_reg;
				rd_next[`PT_STAT_EXT_BIT] = ers_s2_reg;
			end
			`PT_OFS_CLKDIV: begin
				rd_next[7:0] = clkdiv_reg;
			end
			default: begin
				rd_next = 32'h0000_0000;
			end
		endcase
	end

	always @(posedge core_clk) begin
		if (srst) begin
			avs_readdata <= 32'h0000_0000;
		end else if (avs_read & ~ack_reg) begin
			avs_readdata <= rd_next;
		end
	end

	// Software registers; a write of the run bit wins over a hardware clear
	always @(posedge core_clk) begin
		if (srst) begin
			period_reg <= `PT_RST_PERIOD;
			duty_reg   <= `PT_RST_DUTY;
			mode_reg   <= `PT_RST_MODE;
			clkdiv_reg <= `PT_RST_CLKDIV;
			run_reg    <= 1'b0;
		end else begin
			if (do_write && (avs_address == `PT_OFS_PERIOD)) begin
				period_reg <= avs_writedata[7:0];
			end
			if (do_write && (avs_address == `PT_OFS_DUTY)) begin
				duty_reg <= avs_writedata[7:0];
			end
			if (do_write && (avs_address == `PT_OFS_CLKDIV)) begin
				clkdiv_reg <= avs_writedata[7:0];
			end
			if (wr_ctrl) begin
				mode_reg <= avs_writedata[`PT_CTRL_MODE_MSB:`PT_CTRL_MODE_LSB];
				run_reg  <= avs_writedata[`PT_CTRL_RUN_BIT];
			end else if (hw_clr_run) begin
				run_reg <= 1'b0;
			end
		end
	end

	// Timer clock enable
	always @(posedge core_clk) begin
		if (srst) begin
			div_cnt_reg <= 8'h00;
			tick_reg    <= 1'b0;
		end else if (div_cnt_reg >= clkdiv_reg) begin
			div_cnt_reg <= 8'h00;
			tick_reg    <= 1'b1;
		end else begin
			div_cnt_reg <= div_cnt_reg + 8'h01;
			tick_reg    <= 1'b0;
		end
	end

	// External input synchroniser
	always @(posedge core_clk) begin
		if (srst) begin
			ers_s1_reg <= 1'b0;
			ers_s2_reg <= 1'b0;
		end else begin
			ers_s1_reg <= external_reset_input;
			ers_s2_reg <= ers_s1_reg;
		end
	end

	// Run bit crosses into timer clocks; a hardware clear empties the chain
	always @(posedge core_clk) begin
		if (srst) begin
			run_s1_reg   <= 1'b0;
			run_s2_reg   <= 1'b0;
			run_prev_reg <= 1'b0;
			ers_prev_reg <= 1'b0;
		end else if (hw_clr_run) begin
			run_s1_reg   <= 1'b0;
			run_s2_reg   <= 1'b0;
			run_prev_reg <= 1'b0;
			ers_prev_reg <= ers_s2_reg;
		end else if (tick_reg) begin
			run_s1_reg   <= run_reg;
			run_s2_reg   <= run_s1_reg;
			run_prev_reg <= run_s2_reg;
			ers_prev_reg <= ers_s2_reg;
		end
	end

	assign run  = run_s2_reg;
	assign rise = ers_s2_reg & ~ers_prev_reg;
	assign fall = ~ers_s2_reg & ers_prev_reg;

	assign sel_edge =
		((mode_reg == `PT_MODE_LIM_ANY) || (mode_reg == `PT_MODE_OS_ANY)) ? (rise | fall) :
		((mode_reg == `PT_MODE_LIM_RISE) || (mode_reg == `PT_MODE_OS_RISE) ||
		 (mode_reg == `PT_MODE_HL_RISE) || (mode_reg == `PT_MODE_LR_LO)) ? rise :
		((mode_reg == `PT_MODE_LIM_FALL) || (mode_reg == `PT_MODE_OS_FALL) ||
		 (mode_reg == `PT_MODE_HL_FALL) || (mode_reg == `PT_MODE_LR_HI)) ? fall : 1'b0;

	assign gate_ok = (mode_reg == `PT_MODE_GATE_HI) ? ers_s2_reg :
		(mode_reg == `PT_MODE_GATE_LO) ? ~ers_s2_reg : 1'b1;

	assign lvl_rst = ((mode_reg == `PT_MODE_LVL_LO) || (mode_reg == `PT_MODE_LR_LO)) ? ~ers_s2_reg :
		((mode_reg == `PT_MODE_LVL_HI) || (mode_reg == `PT_MODE_LR_HI)) ? ers_s2_reg : 1'b0;

	assign lvl_held    = is_lvl_limit(mode_reg) && (lvl_cnt_reg == `PT_LVL_TICKS);
	assign lvl_release = lvl_held & ~lvl_rst;

	assign start_evt  = is_edge_start(mode_reg) & run & ~started_reg & sel_edge;
	assign retrig_evt = (is_edge_limit(mode_reg) & run & sel_edge) |
		(is_hl_oneshot(mode_reg) & run & started_reg & sel_edge);

	always @* begin
		case (mode_reg)
			`PT_MODE_SWGATE, `PT_MODE_GATE_HI, `PT_MODE_GATE_LO: begin
				inc_raw = run & gate_ok;
			end
			`PT_MODE_LIM_ANY, `PT_MODE_LIM_RISE, `PT_MODE_LIM_FALL, `PT_MODE_OS_SW: begin
				inc_raw = run;
			end
			`PT_MODE_LVL_LO, `PT_MODE_LVL_HI: begin
				inc_raw = run & ~lvl_held;
			end
			`PT_MODE_OS_RISE, `PT_MODE_OS_FALL, `PT_MODE_OS_ANY, `PT_MODE_HL_RISE, `PT_MODE_HL_FALL: begin
				inc_raw = run & started_reg;
			end
			`PT_MODE_LR_LO, `PT_MODE_LR_HI: begin
				inc_raw = run & started_reg & ~lvl_rst;
			end
			default: begin
				inc_raw = 1'b0;
			end
		endcase
	end

	assign inc        = tick_reg & inc_raw & (hold_reg == 2'h0) & ~retrig_evt & ~lvl_release;
	assign match      = (tb_count == period_reg);
	assign duty_hit   = (tb_count == duty_reg);
	assign hw_clr_run = inc & match & is_oneshot(mode_reg);
	assign sw_start   = (mode_reg == `PT_MODE_OS_SW) & run & ~run_prev_reg & (tb_count == 8'h00);

	// Drive starts: cycle wrap, hold expiry, start edge, reset edges, software start
	assign pwm_set = tick_reg & (
		(inc & match & ~is_oneshot(mode_reg)) |
		(hold_reg == 2'h1) |
		start_evt |
		(retrig_evt & is_hl_oneshot(mode_reg)) |
		sw_start);
	assign pwm_clr = inc & duty_hit;

	// Counter and start state
	always @(posedge core_clk) begin
		if (srst) begin
			tb_count     <= `PT_RST_COUNT;
			hold_reg     <= 2'h0;
			lvl_cnt_reg  <= 2'h0;
			started_reg  <= 1'b0;
			period_match <= 1'b0;
		end else begin
			period_match <= inc & match;
			if (tick_reg) begin
				if (~run | ~lvl_rst | ~is_lvl_limit(mode_reg)) begin
					lvl_cnt_reg <= 2'h0;
				end else if (lvl_cnt_reg != `PT_LVL_TICKS) begin
					lvl_cnt_reg <= lvl_cnt_reg + 2'h1;
				end
				if (~run | hw_clr_run) begin
					started_reg <= 1'b0;
				end else if (is_lvl_oneshot(mode_reg) & lvl_rst) begin
					started_reg <= 1'b0;
				end else if (start_evt) begin
					started_reg <= 1'b1;
				end
			end
			if (wr_count) begin
				tb_count <= avs_writedata[7:0];
			end else if (tick_reg) begin
				if (retrig_evt) begin
					tb_count <= 8'h00;
					hold_reg <= `PT_HOLD_TICKS;
				end else if (lvl_release) begin
					tb_count <= 8'h00;
					hold_reg <= `PT_HOLD_TICKS;
				end else if (lvl_held | (is_lvl_oneshot(mode_reg) & lvl_rst)) begin
					tb_count <= 8'h00;
				end else if (hold_reg != 2'h0) begin
					tb_count <= 8'h00;
					hold_reg <= hold_reg - 2'h1;
				end else if (inc) begin
					if (match) begin
						tb_count <= 8'h00;
					end else begin
						tb_count <= tb_count + 8'h01;
					end
				end
			end
		end
	end

	// PWM drive; a start wins over a duty match in the same tick
	always @(posedge core_clk) begin
		if (srst) begin
			pwm_out <= 1'b0;
		end else if (pwm_set) begin
			pwm_out <= 1'b1;
		end else if (pwm_clr) begin
			pwm_out <= 1'b0;
		end
	end

endmodule

/* rtl/pt_timer_consts.vh */
`ifndef PT_TIMER_CONSTS_VH
`define PT_TIMER_CONSTS_VH

// Register byte offsets
`define PT_OFS_COUNT      5'h00
`define PT_OFS_PERIOD     5'h04
`define PT_OFS_CTRL       5'h08
`define PT_OFS_DUTY       5'h0c
`define PT_OFS_STATUS     5'h10
`define PT_OFS_CLKDIV     5'h14

// Control register fields
`define PT_CTRL_RUN_BIT   7
`define PT_CTRL_MODE_MSB  4
`define PT_CTRL_MODE_LSB  0

// Status register fields
`define PT_STAT_PWM_BIT   0
`define PT_STAT_RUN_BIT   1
`define PT_STAT_ARM_BIT   2
`define PT_STAT_EXT_BIT   3

// Reset values
`define PT_RST_COUNT      8'h00
`define PT_RST_PERIOD     8'hff
`define PT_RST_DUTY       8'h00
`define PT_RST_MODE       5'h00
`define PT_RST_CLKDIV     8'h00

// Mode codes
`define PT_MODE_SWGATE    5'h00
`define PT_MODE_GATE_HI   5'h01
`define PT_MODE_GATE_LO   5'h02
`define PT_MODE_LIM_ANY   5'h03
`define PT_MODE_LIM_RISE  5'h04
`define PT_MODE_LIM_FALL  5'h05
`define PT_MODE_LVL_LO    5'h06
`define PT_MODE_LVL_HI    5'h07
`define PT_MODE_OS_SW     5'h08
`define PT_MODE_OS_RISE   5'h09
`define PT_MODE_OS_FALL   5'h0a
`define PT_MODE_OS_ANY    5'h0b
`define PT_MODE_HL_RISE   5'h0c
`define PT_MODE_HL_FALL   5'h0d
`define PT_MODE_LR_LO     5'h0e
`define PT_MODE_LR_HI     5'h0f

// Timing counts in timer clocks
`define PT_HOLD_TICKS     2'h2
`define PT_LVL_TICKS      2'h2

`endif

/* verification/pt_ers_model.sv */
module pt_ers_model (
	input  wire core_clk,
	input  wire level_req,
	output wire ers
);
	timeunit 1ns;
	timeprecision 1ps;
	logic ers_reg = 1'b0;
	// Source changes only just after a clock edge
	always @(posedge core_clk)
		ers_reg <= level_req;
	assign ers = ers_reg;
endmodule

/* verification/pt_timer_checker.sv */
`include "pt_timer_consts.vh"
module pt_timer_checker (
	input wire        core_clk,
	input wire        srst,
	input wire [4:0]  avs_address,
	input wire        avs_read,
	input wire        avs_write,
	input wire [31:0] avs_writedata,
	input wire [31:0] avs_readdata,
	input wire        avs_waitrequest,
	input wire        external_reset_input,
	input wire        pwm_out,
	input wire [7:0]  tb_count,
	input wire        period_match
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] per_reg;
	logic [4:0] mode_reg;
	logic       run_reg;
	logic       div0_reg;
	logic [3:0] lo_reg;
	logic [3:0] off_reg;
	wire        req = avs_read | avs_write;
	wire        wr_ok = avs_write & ~avs_waitrequest;
	wire        cnt_wr = wr_ok & (avs_address == `PT_OFS_COUNT);
	wire        gate_stop = ((mode_reg == `PT_MODE_GATE_HI) & ~external_reset_input)
		| ((mode_reg == `PT_MODE_GATE_LO) & external_reset_input);
	wire        stop = (mode_reg < 5'h08) & (~run_reg | gate_stop) & div0_reg & ~cnt_wr;
	wire        low = (mode_reg == `PT_MODE_LVL_LO) & run_reg & ~external_reset_input & div0_reg & ~cnt_wr;
	// Shadow of the software settings seen on the bus
	always @(posedge core_clk) begin
		if (srst) begin
			per_reg <= 8'hff;
			mode_reg <= 5'h00;
			run_reg <= 1'b0;
			div0_reg <= 1'b1;
		end else if (wr_ok) begin
			if (avs_address == `PT_OFS_PERIOD)
				per_reg <= avs_writedata[7:0];
			if (avs_address == `PT_OFS_CTRL) begin
				mode_reg <= avs_writedata[4:0];
				run_reg <= avs_writedata[7];
			end
			if (avs_address == `PT_OFS_CLKDIV)
				div0_reg <= (avs_writedata[7:0] == 8'h00);
		end
	end
	// Cycles spent in a held condition, saturating
	always @(posedge core_clk) begin
		lo_reg <= (srst | ~low) ? 4'h0 : lo_reg + {3'h0, lo_reg != 4'hf};
		off_reg <= (srst | ~stop) ? 4'h0 : off_reg + {3'h0, off_reg != 4'hf};
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	chk_wait_first: assert property (req && !$past(req) |-> avs_waitrequest)
		else $error("no wait state in first cycle");
	chk_one_wait: assert property (req && avs_waitrequest |=> !avs_waitrequest)
		else $error("more than one wait state");
	chk_idle_ready: assert property (!req |-> !avs_waitrequest)
		else $error("waitrequest high while idle");
	chk_count_step: assert property (
		tb_count != $past(tb_count) && !$past(cnt_wr) |-> tb_count == $past(tb_count) + 8'h01 || tb_count == 8'h00)
		else $error("count moved by other than one");
	chk_wrap_zero: assert property (
		$past(tb_count) == $past(per_reg) && tb_count != $past(tb_count) && !$past(cnt_wr) |-> tb_count == 8'h00)
		else $error("count left period value not to zero");
	chk_match_zero: assert property (
		period_match |-> tb_count == 8'h00 && $past(tb_count) == $past(per_reg))
		else $error("match pulse without wrap");
	chk_level_hold: assert property (lo_reg >= 4'h8 |-> tb_count == 8'h00)
		else $error("count not held at zero by level");
	chk_stop_hold: assert property (off_reg >= 4'h8 |-> $stable(tb_count))
		else $error("count moved while stopped");
	cover property (period_match);
	cover property (lo_reg == 4'h8);
	cover property (off_reg == 4'h8);
endmodule
bind pt_timer pt_timer_checker u_chk (.core_clk(core_clk), .srst(srst), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .external_reset_input(external_reset_input), .pwm_out(pwm_out),
	.tb_count(tb_count), .period_match(period_match));

/* verification/tb.sv */
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        core_clk = 1'b0;
	logic        srst = 1'b1;
	logic [4:0]  avs_address = 5'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic        lvl = 1'b0;
	logic [31:0] d;
	logic [7:0]  c;
	wire  [31:0] avs_readdata;
	wire         avs_waitrequest;
	wire         ers;
	wire         pwm_out;
	wire  [7:0]  tb_count;
	wire         period_match;
	int          n_mismatch = 0;
	int          n_compared = 0;
	always #5 core_clk = ~core_clk;
	pt_ers_model u_ers (.core_clk(core_clk), .level_req(lvl), .ers(ers));
	pt_timer dut (.core_clk(core_clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .external_reset_input(ers), .pwm_out(pwm_out),
		.tb_count(tb_count), .period_match(period_match));
	task results;
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// Held until waitrequest is seen low at a rising edge
	task bus(input logic w, input logic [4:0] a, input logic [31:0] v);
		int k;
		k = 0;
		avs_address <= a;
		avs_write <= w;
		avs_read <= ~w;
		avs_writedata <= v;
		do begin
			@(posedge core_clk);
			k++;
		end while (avs_waitrequest !== 1'b0 && k < 20);
		chk("ack", 0, avs_waitrequest);
		d = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge core_clk);
	endtask
	task cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task wait_pm;
		int k;
		k = 0;
		do begin
			@(posedge core_clk);
			k++;
		end while (period_match !== 1'b1 && k < 600);
		chk("match", 1, period_match);
	endtask
	task t_regs;
		bus(0, 5'h04, 0);
		chk("period", 32'hff, d);
		bus(0, 5'h08, 0);
		chk("ctrl", 32'h0, d);
		bus(0, 5'h18, 0);
		chk("unmapped", 32'h0, d);
		bus(1, 5'h0c, 32'h5a);
		bus(0, 5'h0c, 0);
		chk("duty", 32'h5a, d);
	endtask
	task t_swgate;
		int i;
		bus(1, 5'h04, 32'h05);
		bus(1, 5'h08, 32'h80);
		wait_pm;
		chk("wrap", 0, tb_count);
		for (i = 1; i <= 6; i++) begin
			@(posedge core_clk);
			chk("step", i % 6, tb_count);
		end
		bus(1, 5'h08, 32'h00);
		cyc(4);
		c = tb_count;
		cyc(6);
		chk("hold", c, tb_count);
	endtask
	task t_gate;
		int m;
		bus(1, 5'h04, 32'hc8);
		for (m = 1; m <= 2; m++) begin
			lvl <= (m == 2);
			bus(1, 5'h08, 32'h80 | m);
			cyc(6);
			c = tb_count;
			cyc(6);
			chk("gate_stop", c, tb_count);
			lvl <= (m == 1);
			cyc(8);
			chk("gate_run", 1, tb_count > c);
			bus(1, 5'h08, 32'h00);
		end
	endtask
	task t_edge;
		int m;
		for (m = 3; m <= 5; m++) begin
			lvl <= (m == 5);
			bus(1, 5'h08, 32'h80 | m);
			cyc(20);
			chk("edge_pre", 1, tb_count > 8'h08);
			lvl <= (m != 5);
			cyc(6);
			chk("edge_reset", 1, tb_count < 8'h08);
			bus(1, 5'h08, 32'h00);
		end
	endtask
	task t_level;
		lvl <= 1'b1;
		bus(1, 5'h08, 32'h86);
		cyc(6);
		lvl <= 1'b0;
		cyc(10);
		chk("lvl_hold", 0, tb_count);
		lvl <= 1'b1;
		cyc(12);
		chk("lvl_run", 1, tb_count > 8'h02);
		bus(1, 5'h08, 32'h06);
		cyc(6);
		lvl <= 1'b0;
		c = tb_count;
		cyc(10);
		chk("lvl_ignore", c, tb_count);
	endtask
	task t_oneshot;
		bus(1, 5'h00, 32'h00);
		bus(1, 5'h04, 32'h0a);
		bus(1, 5'h08, 32'h88);
		wait_pm;
		cyc(8);
		chk("os_count", 0, tb_count);
		bus(0, 5'h08, 0);
		chk("os_run", 0, d[7]);
	endtask
	task t_edge_os;
		lvl <= 1'b0;
		bus(1, 5'h0c, 32'h03);
		bus(1, 5'h08, 32'h89);
		cyc(10);
		chk("eos_idle", 0, tb_count);
		lvl <= 1'b1;
		wait_pm;
		bus(0, 5'h08, 0);
		chk("eos_run", 0, d[7]);
		chk("eos_pwm", 0, pwm_out);
	endtask
	task t_hl;
		bus(1, 5'h04, 32'h28);
		lvl <= 1'b0;
		bus(1, 5'h08, 32'h8c);
		cyc(6);
		chk("hl_idle", 0, tb_count);
		lvl <= 1'b1;
		cyc(6);
		chk("hl_pwm_on", 1, pwm_out);
		cyc(10);
		chk("hl_pwm_off", 0, pwm_out);
		lvl <= 1'b0;
		cyc(2);
		lvl <= 1'b1;
		cyc(6);
		chk("hl_reset", 0, tb_count);
		chk("hl_pwm_re", 1, pwm_out);
		wait_pm;
		bus(0, 5'h08, 0);
		chk("hl_run", 0, d[7]);
		chk("hl_pwm_end", 0, pwm_out);
	endtask
	task t_lr;
		lvl <= 1'b0;
		bus(1, 5'h08, 32'h8e);
		cyc(8);
		chk("lr_held", 0, tb_count);
		lvl <= 1'b1;
		cyc(6);
		chk("lr_pwm_on", 1, pwm_out);
		cyc(10);
		chk("lr_run", 1, tb_count > 8'h08);
		wait_pm;
		bus(0, 5'h08, 0);
		chk("lr_halt", 0, d[7]);
		cyc(4);
		chk("lr_pwm_end", 0, pwm_out);
		bus(1, 5'h08, 32'h8e);
		cyc(10);
		chk("lr_need_edge", 0, tb_count);
		bus(1, 5'h08, 32'h8f);
		lvl <= 1'b0;
		cyc(8);
		chk("lrh_run", 1, tb_count > 8'h00);
		lvl <= 1'b1;
		cyc(6);
		chk("lrh_hold", 0, tb_count);
		bus(1, 5'h08, 32'h00);
	endtask
	task t_misc;
		int m;
		bus(1, 5'h08, 32'h87);
		lvl <= 1'b0;
		cyc(12);
		chk("lvlh_run", 1, tb_count > 8'h02);
		lvl <= 1'b1;
		cyc(10);
		chk("lvlh_hold", 0, tb_count);
		bus(1, 5'h08, 32'h07);
		for (m = 10; m <= 13; m++) begin
			if (m != 12) begin
				lvl <= 1'b1;
				cyc(6);
				bus(1, 5'h08, 32'h80 | m);
				cyc(8);
				chk("os_wait", 0, tb_count);
				lvl <= 1'b0;
				wait_pm;
				bus(0, 5'h08, 0);
				chk("os_clear", 0, d[7]);
			end
		end
		bus(1, 5'h14, 32'h01);
		bus(1, 5'h08, 32'h80);
		cyc(40);
		chk("div_rate", 1, tb_count >= 8'h0f && tb_count <= 8'h15);
		bus(0, 5'h10, 0);
		chk("stat_run", 1, d[1]);
		bus(1, 5'h08, 32'h00);
		bus(1, 5'h14, 32'h00);
	endtask
	initial begin
		repeat (2) @(posedge core_clk);
		srst <= 1'b0;
		@(posedge core_clk);
		t_regs;
		t_swgate;
		t_gate;
		t_edge;
		t_level;
		t_oneshot;
		t_edge_os;
		t_hl;
		t_lr;
		t_misc;
		results;
	end
	initial begin
		repeat (20000) @(posedge core_clk);
		n_mismatch++;
		results;
	end
endmodule
